//--- common/char_lcd_pkg.sv
// Notes on behaviour
// - The host bus runs 4 or 8 bits wide as chosen by the bus width select bit of the instruction.
// - Register select and read/write decode to instruction write, status read, data write, data read.
// - A status read returns the in-progress flag on bus bit 7 and the RAM pointer on bits 6 to 0.
// - The in-progress flag is high while an internal operation runs and instructions are refused.
// - After the host reads the data holding register it is reloaded from the next RAM address.
// - After the host writes the data holding register the byte is stored at the pointer address.
// - The instruction register only takes instruction writes and is never returned on a read.
// - The RAM pointer steps up by 1 after each RAM write and down by 1 after each RAM read.
// - An address setting instruction loads the pointer and selects display RAM or glyph RAM.
// - Display RAM holds up to 80 bytes addressed by a 7-bit pointer, bit 6 most significant.
// - In one-line mode valid display addresses run from 00h through 4fh.
// - In two-line mode valid display addresses are 00h to 27h and 40h to 67h.
// - Glyph RAM holds 8 user glyphs of 5x8 dots or 4 of 5x11 dots, written by the host.
// - Glyph ROM provides 204 fixed 5x8 patterns and 32 fixed 5x11 patterns.
package char_lcd_pkg;

	// ----------------------------------------
	// Pin sample layout
	// ----------------------------------------
	localparam int PIN_W = 11;
	localparam int PIN_EN = 10;
	localparam int PIN_RS = 9;
	localparam int PIN_RW = 8;
	localparam int BYTE_W = 8;
	localparam int STATUS_BUSY_BIT = 7;

	// ----------------------------------------
	// Instruction fields
	// ----------------------------------------
	localparam int INSN_SET_DISP_BIT = 7;
	localparam int INSN_SET_GLYPH_BIT = 6;
	localparam int INSN_FUNC_BIT = 5;
	localparam int FUNC_WIDTH_BIT = 4;
	localparam int FUNC_LINES_BIT = 3;
	localparam int FUNC_FONT_BIT = 2;

	// ----------------------------------------
	// Memory map
	// ----------------------------------------
	localparam int DISP_DEPTH = 80;
	localparam int GLYPH_DEPTH = 64;
	localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
	localparam logic [6:0] LINE1_FIRST = 7'h00;
	localparam logic [6:0] LINE1_LAST = 7'h27;
	localparam logic [6:0] LINE2_FIRST = 7'h40;
	localparam logic [6:0] LINE2_LAST = 7'h67;
	localparam logic [6:0] LINE2_INDEX_BASE = 7'h28;
	localparam logic [7:0] GLYPH_ROM_BASE = 8'h10;
	localparam logic [7:0] GLYPH_SMALL_COUNT = 8'hcc;
	localparam logic [7:0] GLYPH_TALL_COUNT = 8'h20;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic RST_WIDE_BUS = 1'b1;
	localparam logic RST_TWO_LINE = 1'b0;
	localparam logic RST_TALL_FONT = 1'b0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int EXEC_TIME_NS = 37000;
	localparam int EXEC_CYCLES = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXEC_CNT_W = 11;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [1:0] {
		ACC_INSN_WR,
		ACC_STATUS_RD,
		ACC_DATA_WR,
		ACC_DATA_RD
	} acc_type_type;

endpackage

//--- logic/char_lcd_host_port.sv
`timescale 1ns/100ps

// ----------------------------------------
// Write queue
// ----------------------------------------
module byte_queue #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store_q [0:DEPTH-1];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign in_ready_o = count_q != (AW+1)'(DEPTH);
	assign out_valid_o = count_q != '0;
	assign out_data_o = store_q[rd_ptr_q];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge clock_i) begin
		if (clk_en_i && push) begin
			store_q[wr_ptr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else if (clk_en_i) begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule

// ----------------------------------------
// Host port
// ----------------------------------------
module char_lcd_host_port import char_lcd_pkg::*; (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic enable_strobe_i,
	input wire logic register_select_i,
	input wire logic read_not_write_i,
	input wire logic [7:0] bus_i,
	output logic [7:0] bus_o,
	output logic bus_oe_n_o,
	input wire logic [7:0] glyph_code_i,
	input wire logic [3:0] glyph_row_i,
	output logic [4:0] glyph_row_o,
	output logic bus_width_select_o,
	output logic two_line_o,
	output logic tall_font_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic acc_type_type decode_access(input logic rs, input logic rw);
		acc_type_type a;
		a = ACC_INSN_WR;
		unique case ({rs, rw})
			2'b00: a = ACC_INSN_WR;
			2'b01: a = ACC_STATUS_RD;
			2'b10: a = ACC_DATA_WR;
			2'b11: a = ACC_DATA_RD;
		endcase
		return a;
	endfunction

	function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic up,
			input logic two, input logic glyph);
		logic [6:0] r;
		r = up ? p + 7'h01 : p - 7'h01;
		if (glyph) begin
			r[6] = 1'b0;
		end else if (!two) begin
			if (up && p >= ONE_LINE_LAST) begin
				r = LINE1_FIRST;
			end else if (!up && p == LINE1_FIRST) begin
				r = ONE_LINE_LAST;
			end
		end else begin
			if (up && p == LINE1_LAST) begin
				r = LINE2_FIRST;
			end else if (up && p >= LINE2_LAST) begin
				r = LINE1_FIRST;
			end else if (!up && p == LINE2_FIRST) begin
				r = LINE1_LAST;
			end else if (!up && p == LINE1_FIRST) begin
				r = LINE2_LAST;
			end
		end
		return r;
	endfunction

	// Bit 7 flags an address inside the active map, bits 6..0 give the array index
	function automatic logic [7:0] disp_slot(input logic [6:0] p, input logic two);
		logic [7:0] s;
		s = 8'h00;
		if (!two) begin
			s = {p <= ONE_LINE_LAST, p};
		end else if (p <= LINE1_LAST) begin
			s = {1'b1, p};
		end else if (p >= LINE2_FIRST && p <= LINE2_LAST) begin
			s = {1'b1, p - LINE2_FIRST + LINE2_INDEX_BASE};
		end
		return s;
	endfunction

	// Fixed patterns are a generated stand-in until the real font table is dropped in
	function automatic logic [4:0] rom_row(input logic [7:0] code, input logic [3:0] row,
			input logic tall);
		logic [7:0] idx;
		idx = code - GLYPH_ROM_BASE;
		rom_row = 5'h00;
		if (!tall && idx < GLYPH_SMALL_COUNT && row < 4'h8) begin
			rom_row = code[4:0] ^ {row[2:0], row[1:0]};
		end else if (idx >= GLYPH_SMALL_COUNT && idx < GLYPH_SMALL_COUNT + GLYPH_TALL_COUNT
				&& row < 4'hb) begin
			rom_row = ~code[4:0] ^ {row, row[0]};
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [PIN_W-1:0] pin_s1_q;
	logic [PIN_W-1:0] pin_s2_q;
	logic [PIN_W-1:0] pin_s3_q;
	logic [PIN_W-1:0] pin_lvl_q;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
			pin_lvl_q <= '0;
		end else if (clk_en_i) begin
			pin_s1_q <= {enable_strobe_i, register_select_i, read_not_write_i, bus_i};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			// A bit only moves once two stages agree, so a glitch cannot fake a strobe
			for (int i = 0; i < PIN_W; i++) begin
				if (pin_s2_q[i] == pin_s3_q[i]) begin
					pin_lvl_q[i] <= pin_s3_q[i];
				end
			end
		end
	end

	logic en_rise;
	logic en_fall;
	acc_type_type acc;
	logic [7:0] db_in;

	assign en_rise = !pin_lvl_q[PIN_EN] && pin_s2_q[PIN_EN] && pin_s3_q[PIN_EN];
	assign en_fall = pin_lvl_q[PIN_EN] && !pin_s2_q[PIN_EN] && !pin_s3_q[PIN_EN];
	assign acc = decode_access(pin_lvl_q[PIN_RS], pin_lvl_q[PIN_RW]);
	assign db_in = pin_lvl_q[7:0];

	// ----------------------------------------
	// Mode and nibble state
	// ----------------------------------------
	logic wide_bus_q;
	logic two_line_q;
	logic tall_font_q;
	logic glyph_sel_q;
	logic nib_phase_q;
	logic [3:0] hi_nib_q;
	logic [7:0] instruction_code_reg;
	logic [6:0] ram_pointer_q;
	logic [7:0] data_holding_q;
	logic [EXEC_CNT_W-1:0] exec_cnt_q;
	logic refill_q;
	logic byte_done;
	logic [7:0] byte_in;
	logic busy;
	logic insn_take;
	logic q_in_ready;
	logic q_out_valid;
	logic [7:0] q_out_data;
	logic drain;

	assign byte_done = en_fall && (wide_bus_q || nib_phase_q);
	assign byte_in = wide_bus_q ? db_in : {hi_nib_q, db_in[7:4]};
	assign busy = exec_cnt_q != '0 || q_out_valid;
	assign insn_take = byte_done && acc == ACC_INSN_WR && !busy;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			nib_phase_q <= 1'b0;
			hi_nib_q <= 4'h0;
		end else if (clk_en_i) begin
			if (insn_take && byte_in[7:INSN_FUNC_BIT] == 3'h1) begin
				nib_phase_q <= 1'b0;
			end else if (en_fall && !wide_bus_q) begin
				nib_phase_q <= !nib_phase_q;
				if (!nib_phase_q) begin
					hi_nib_q <= db_in[7:4];
				end
			end
		end
	end

	// The code register is write-only; nothing routes it back to the bus
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			instruction_code_reg <= 8'h00;
		end else if (clk_en_i && byte_done && acc == ACC_INSN_WR && !busy) begin
			instruction_code_reg <= byte_in;
		end
	end

	// ----------------------------------------
	// Instruction execution
	// ----------------------------------------
	logic exec_q;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			exec_q <= 1'b0;
			exec_cnt_q <= '0;
		end else if (clk_en_i) begin
			exec_q <= insn_take;
			if (insn_take) begin
				exec_cnt_q <= EXEC_CNT_W'(EXEC_CYCLES);
			end else if (exec_cnt_q != '0) begin
				exec_cnt_q <= exec_cnt_q - 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wide_bus_q <= RST_WIDE_BUS;
			two_line_q <= RST_TWO_LINE;
			tall_font_q <= RST_TALL_FONT;
		end else if (clk_en_i && exec_q && instruction_code_reg[7:INSN_FUNC_BIT] == 3'h1) begin
			wide_bus_q <= instruction_code_reg[FUNC_WIDTH_BIT];
			two_line_q <= instruction_code_reg[FUNC_LINES_BIT];
			tall_font_q <= instruction_code_reg[FUNC_FONT_BIT];
		end
	end

	// ----------------------------------------
	// Write queue and RAM pointer
	// ----------------------------------------
	// Queued bytes wait for a running instruction so an address set lands first
	assign drain = q_out_valid && exec_cnt_q == '0 && !exec_q && !byte_done;

	byte_queue #(
		.WIDTH(BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) write_queue (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.clk_en_i(clk_en_i),
		.in_valid_i(byte_done && acc == ACC_DATA_WR),
		.in_ready_o(q_in_ready),
		.in_data_i(byte_in),
		.out_valid_o(q_out_valid),
		.out_ready_i(drain),
		.out_data_o(q_out_data)
	);

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ram_pointer_q <= 7'h00;
			glyph_sel_q <= 1'b0;
			refill_q <= 1'b0;
		end else if (clk_en_i) begin
			refill_q <= 1'b0;
			if (exec_q && instruction_code_reg[INSN_SET_DISP_BIT]) begin
				ram_pointer_q <= instruction_code_reg[6:0];
				glyph_sel_q <= 1'b0;
				refill_q <= 1'b1;
			end else if (exec_q && instruction_code_reg[7:INSN_SET_GLYPH_BIT] == 2'h1) begin
				ram_pointer_q <= {1'b0, instruction_code_reg[5:0]};
				glyph_sel_q <= 1'b1;
				refill_q <= 1'b1;
			end else if (byte_done && acc == ACC_DATA_RD) begin
				ram_pointer_q <= step_ptr(ram_pointer_q, 1'b0, two_line_q, glyph_sel_q);
				refill_q <= 1'b1;
			end else if (drain) begin
				ram_pointer_q <= step_ptr(ram_pointer_q, 1'b1, two_line_q, glyph_sel_q);
			end
		end
	end

	// ----------------------------------------
	// Display and glyph RAM
	// ----------------------------------------
	logic [7:0] display_ram [0:DISP_DEPTH-1];
	logic [7:0] glyph_ram [0:GLYPH_DEPTH-1];
	logic [7:0] slot;
	logic [7:0] ram_rd;

	assign slot = disp_slot(ram_pointer_q, two_line_q);
	assign ram_rd = glyph_sel_q ? glyph_ram[ram_pointer_q[5:0]]
		: (slot[7] ? display_ram[slot[6:0]] : 8'h00);

	always_ff @(posedge clock_i) begin
		if (clk_en_i && drain) begin
			if (glyph_sel_q) begin
				glyph_ram[ram_pointer_q[5:0]] <= q_out_data;
			end else if (slot[7]) begin
				display_ram[slot[6:0]] <= q_out_data;
			end
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			data_holding_q <= 8'h00;
		end else if (clk_en_i) begin
			if (refill_q) begin
				data_holding_q <= ram_rd;
			end else if (drain) begin
				data_holding_q <= q_out_data;
			end
		end
	end

	// ----------------------------------------
	// Bus drive
	// ----------------------------------------
	logic [7:0] rd_byte;
	logic [7:0] rd_hold_q;

	assign rd_byte = acc == ACC_STATUS_RD ? {busy, ram_pointer_q} : data_holding_q;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bus_o <= 8'h00;
			bus_oe_n_o <= 1'b1;
			rd_hold_q <= 8'h00;
		end else if (clk_en_i) begin
			if (en_rise && pin_lvl_q[PIN_RW]) begin
				bus_oe_n_o <= 1'b0;
				if (wide_bus_q) begin
					bus_o <= rd_byte;
				end else if (!nib_phase_q) begin
					rd_hold_q <= rd_byte;
					bus_o <= {rd_byte[7:4], 4'h0};
				end else begin
					bus_o <= {rd_hold_q[3:0], 4'h0};
				end
			end else if (en_fall) begin
				bus_oe_n_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Glyph lookup and mode outputs
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			glyph_row_o <= 5'h00;
			bus_width_select_o <= RST_WIDE_BUS;
			two_line_o <= RST_TWO_LINE;
			tall_font_o <= RST_TALL_FONT;
		end else if (clk_en_i) begin
			bus_width_select_o <= wide_bus_q;
			two_line_o <= two_line_q;
			tall_font_o <= tall_font_q;
			if (glyph_code_i < GLYPH_ROM_BASE) begin
				glyph_row_o <= tall_font_q
					? glyph_ram[{glyph_code_i[2:1], glyph_row_i}][4:0]
					: glyph_ram[{glyph_code_i[2:0], glyph_row_i[2:0]}][4:0];
			end else begin
				glyph_row_o <= rom_row(glyph_code_i, glyph_row_i, tall_font_q);
			end
		end
	end
endmodule

//--- sim/char_lcd_host_port_assertions.sv
`timescale 1ns/100ps

// ----------------------------------------
// Port checker
// ----------------------------------------
module char_lcd_host_port_checker (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic enable_strobe_i,
	input wire logic read_not_write_i,
	input wire logic [7:0] bus_o,
	input wire logic bus_oe_n_o,
	input wire logic [7:0] glyph_code_i,
	input wire logic [3:0] glyph_row_i,
	input wire logic [4:0] glyph_row_o,
	input wire logic bus_width_select_o,
	input wire logic two_line_o,
	input wire logic tall_font_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	// Saturates so a long idle never wraps into a false recent fall
	logic [3:0] since_fall_q;
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			since_fall_q <= 4'hf;
		end else if ($fell(enable_strobe_i)) begin
			since_fall_q <= 4'h0;
		end else if (since_fall_q != 4'hf) begin
			since_fall_q <= since_fall_q + 4'h1;
		end
	end

	a_drive_only_reads: assert property (!bus_oe_n_o |-> read_not_write_i)
		else $error("bus driven outside a read");
	a_read_drive_time: assert property (clk_en_i && $rose(enable_strobe_i) && read_not_write_i
		|-> ##[2:5] !bus_oe_n_o)
		else $error("read data not driven in time");
	a_write_no_drive: assert property ($rose(enable_strobe_i) && !read_not_write_i
		|-> bus_oe_n_o [*8])
		else $error("bus driven during a write");
	a_release_after_fall: assert property ($fell(enable_strobe_i) |-> ##[2:5] bus_oe_n_o)
		else $error("bus not released after strobe fall");
	a_drive_stands: assert property (!bus_oe_n_o && enable_strobe_i |=> !bus_oe_n_o)
		else $error("read data dropped while strobe high");
	a_mode_after_insn: assert property ($changed(bus_width_select_o) || $changed(two_line_o)
		|| $changed(tall_font_o) |-> since_fall_q <= 4'ha)
		else $error("mode changed without an access");
	a_narrow_low_zero: assert property (!bus_width_select_o && !bus_oe_n_o
		|-> bus_o[3:0] == 4'h0)
		else $error("low lines not zero in narrow mode");
	a_rom_row_steady: assert property ($past(arst_n_i) && clk_en_i && $past(clk_en_i)
		&& glyph_code_i >= 8'h10 && $stable(glyph_code_i) && $stable(glyph_row_i)
		|=> $stable(glyph_row_o) || $changed(tall_font_o))
		else $error("fixed glyph row not steady");
endmodule

bind char_lcd_host_port char_lcd_host_port_checker checker_inst (
	.clock_i(clock_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
	.enable_strobe_i(enable_strobe_i), .read_not_write_i(read_not_write_i),
	.bus_o(bus_o), .bus_oe_n_o(bus_oe_n_o), .glyph_code_i(glyph_code_i),
	.glyph_row_i(glyph_row_i), .glyph_row_o(glyph_row_o),
	.bus_width_select_o(bus_width_select_o), .two_line_o(two_line_o),
	.tall_font_o(tall_font_o)
);

//--- sim/char_lcd_host_port_tb.sv
`timescale 1ns/100ps

module char_lcd_host_port_tb;
	import char_lcd_pkg::*;
	logic clock_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic strobe, rs, rnw, oe_n, wide, two, tall;
	logic [7:0] to_dev, from_dev, glyph_code, rd;
	logic [3:0] glyph_row = 4'h0;
	logic [4:0] glyph_out;
	logic clk_en = 1'b1;
	int num_errors = 0;
	int num_checks = 0;

	always #12.5 clock_i = ~clock_i;

	char_lcd_host_port DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en),
		.enable_strobe_i(strobe), .register_select_i(rs), .read_not_write_i(rnw),
		.bus_i(to_dev), .bus_o(from_dev), .bus_oe_n_o(oe_n), .glyph_code_i(glyph_code),
		.glyph_row_i(glyph_row), .glyph_row_o(glyph_out), .bus_width_select_o(wide),
		.two_line_o(two), .tall_font_o(tall));
	host_bus_model host (.clock_i(clock_i), .enable_strobe_o(strobe),
		.register_select_o(rs), .read_not_write_o(rnw), .bus_o(to_dev), .bus_i(from_dev));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic op(input logic r, input logic w, input logic [7:0] d);
		host.access(r, w, d, rd);
	endtask

	task automatic insn(input logic [7:0] d);
		op(1'b0, 1'b0, d);
		host.wait_idle();
	endtask

	task automatic stat(input logic [7:0] exp);
		op(1'b0, 1'b1, 8'h00);
		check("status", rd, exp);
	endtask

	initial begin
		repeat (60000) @(posedge clock_i);
		num_errors++;
		print_verdict();
	end

	initial begin
		glyph_code = 8'h20;
		repeat (4) @(posedge clock_i);
		#1;
		arst_n_i = 1'b1;
		check("width", {7'h00, wide}, 8'h01);
		check("lines", {6'h00, two, tall}, 8'h00);
		stat(8'h00);
		insn(8'h85);
		stat(8'h05);
		op(1'b1, 1'b0, 8'h41);
		op(1'b1, 1'b0, 8'h42);
		op(1'b1, 1'b0, 8'h43);
		host.wait_idle();
		stat(8'h08);
		op(1'b0, 1'b0, 8'h87);
		stat(8'h87);
		op(1'b0, 1'b0, 8'h90);
		host.wait_idle();
		stat(8'h07);
		op(1'b1, 1'b1, 8'h00);
		check("read", rd, 8'h43);
		op(1'b1, 1'b1, 8'h00);
		check("read", rd, 8'h42);
		stat(8'h05);
		insn(8'h38);
		check("lines", {6'h00, two, tall}, 8'h02);
		insn(8'ha7);
		op(1'b1, 1'b0, 8'h55);
		host.wait_idle();
		stat(8'h40);
		insn(8'h30);
		insn(8'hcf);
		op(1'b1, 1'b0, 8'h66);
		host.wait_idle();
		stat(8'h00);
		insn(8'hcf);
		op(1'b1, 1'b1, 8'h00);
		check("read", rd, 8'h66);
		// Writes pile up behind the busy instruction until the queue refuses
		op(1'b0, 1'b0, 8'h80);
		for (int i = 0; i < 17; i++) begin
			op(1'b1, 1'b0, 8'(i));
		end
		host.wait_idle();
		stat(8'h10);
		insn(8'h40);
		op(1'b1, 1'b0, 8'h0e);
		op(1'b1, 1'b0, 8'h11);
		host.wait_idle();
		#1;
		glyph_code = 8'h00;
		glyph_row = 4'h1;
		repeat (2) @(posedge clock_i);
		#1;
		check("glyph", {3'h0, glyph_out}, 8'h11);
		// The host must switch its own width before polling, or the nibbles pair wrongly
		op(1'b0, 1'b0, 8'h20);
		host.wide_q = 1'b0;
		host.wait_idle();
		check("width", {7'h00, wide}, 8'h00);
		insn(8'h8a);
		stat(8'h0a);
		op(1'b0, 1'b0, 8'h30);
		host.wide_q = 1'b1;
		host.wait_idle();
		check("width", {7'h00, wide}, 8'h01);
		// A whole write strobe while the clock enable is low must pass unseen
		#1;
		clk_en = 1'b0;
		op(1'b1, 1'b0, 8'h77);
		#1;
		clk_en = 1'b1;
		stat(8'h0a);
		print_verdict();
	end
endmodule

//--- sim/host_bus_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// Host processor model
// ----------------------------------------
module host_bus_model (
	input wire logic clock_i,
	output logic enable_strobe_o,
	output logic register_select_o,
	output logic read_not_write_o,
	output logic [7:0] bus_o,
	input wire logic [7:0] bus_i
);
	logic wide_q = 1'b1;

	initial begin
		enable_strobe_o = 1'b0;
		register_select_o = 1'b0;
		read_not_write_o = 1'b0;
		bus_o = 8'h00;
	end

	// Six cycles each side of the fall covers the synchroniser with margin
	task automatic strobe(input logic rs, input logic rnw, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clock_i);
		#1;
		register_select_o = rs;
		read_not_write_o = rnw;
		bus_o = rnw ? ~bus_o : d;
		// Select lines lead the strobe so the synchroniser has them settled at its rise
		repeat (2) @(posedge clock_i);
		#1;
		enable_strobe_o = 1'b1;
		repeat (6) @(posedge clock_i);
		q = bus_i;
		#1;
		enable_strobe_o = 1'b0;
		repeat (6) @(posedge clock_i);
	endtask

	task automatic access(input logic rs, input logic rnw, input logic [7:0] d,
		output logic [7:0] q);
		logic [7:0] hi;
		logic [7:0] lo;
		if (wide_q) begin
			strobe(rs, rnw, d, q);
		end else begin
			strobe(rs, rnw, d, hi);
			strobe(rs, rnw, {d[3:0], 4'h0}, lo);
			q = {hi[7:4], lo[7:4]};
		end
	endtask

	task automatic wait_idle();
		logic [7:0] s;
		s = 8'hff;
		for (int i = 0; i < 200 && s[7] !== 1'b0; i++) begin
			access(1'b0, 1'b1, 8'h00, s);
		end
	endtask
endmodule
